// [hdl/mlt_timer.v]
// Decided for this implementation: strobed register access and the register offsets.
`timescale 1ns/10ps
`include "mlt_regs.vh"
module mlt_timer #(
    parameter [22:0] FILT_CYC = `MLT_T_FILT_MS * 1000 * `MLT_CLK_MHZ,
    parameter [26:0] LOCK_CYC = `MLT_T_LOCK_MS * 1000 * `MLT_CLK_MHZ,
    parameter [25:0] OC_CYC = `MLT_T_OC_MS * 1000 * `MLT_CLK_MHZ
) (
    // clock and reset
    input wire CLOCK,
    input wire ARST_N,
    // supply and temperature
    input wire SUPPLY_OK,
    input wire OVER_TEMP,
    // mode and triggers
    input wire [1:0] MODE_SEL,
    input wire EN_ABOVE_TURNON,
    input wire EN_ABOVE_2V,
    input wire EN_ABOVE_0V5,
    input wire WIN_ABOVE_UPPER,
    input wire WIN_BELOW_LOWER,
    // timing sources
    input wire OSC_LEVEL,
    input wire SYNC_BELOW,
    // shunt_current_sense comparators
    input wire SHUNT_ABOVE_500MV,
    input wire SHUNT_ABOVE_100MV,
    // register port
    input wire [1:0] ADDR,
    input wire [7:0] WR_DATA,
    input wire WR_EN,
    input wire RD_EN,
    output reg [7:0] RD_DATA,
    // gate_drive_output control
    output reg GATE_ON,
    output reg ANGLE_MAX,
    output reg STATIC_OUT,
    output reg FAST_OFF,
    output reg EN_THR_HIGH
);
    // ****************************************
    // states
    // ****************************************
    localparam [3:0] ST_IDLE = 4'h1;
    localparam [3:0] ST_FULL = 4'h2;
    localparam [3:0] ST_RED = 4'h4;
    localparam [3:0] ST_ENO = 4'h8;

    // ****************************************
    // input synchronisation
    // ****************************************
    wire [12:0] s;
    mlt_sync #(.W(13)) u_sync (
        .clk(CLOCK),
        .arst_n(ARST_N),
        .din({SUPPLY_OK, OVER_TEMP, MODE_SEL, EN_ABOVE_TURNON,
              EN_ABOVE_2V, EN_ABOVE_0V5, WIN_ABOVE_UPPER,
              WIN_BELOW_LOWER, OSC_LEVEL, SYNC_BELOW,
              SHUNT_ABOVE_500MV, SHUNT_ABOVE_100MV}),
        .dout(s)
    );
    wire sup_ok = s[12];
    wire ot_in = s[11];
    wire [1:0] mode = s[10:9];
    wire en_on = s[8];
    wire en_2v = s[7];
    wire en_0v5 = s[6];
    wire win_act = s[5] | s[4];
    wire osc = s[3];
    wire sync_lo = s[2];
    wire sh_500 = s[1];
    wire sh_100 = s[0];

    reg [3:0] state;
    reg [3:0] next_state;
    reg [10:0] trk;
    reg [26:0] lock_cnt;
    reg [25:0] integ;
    reg osc_d, sync_d, en_act, first_cycle, pwr_run;
    reg hw_oc, sc_latch, oc_latch, ot_latch, allow;
    reg gate_d;
    wire srst = !sup_ok;

    // ****************************************
    // events and mode decode
    // ****************************************
    wire tick = osc & !osc_d;
    wire zc = sync_lo & !sync_d;
    wire m_static = (mode == `MLT_MODE_STATIC);
    wire m_swoff = (mode == `MLT_MODE_SWOFF);
    wire m_plain = !m_static && !m_swoff;
    wire trk_end = tick && (trk == `MLT_TRK_LAST);
    wire trk_3q = tick && (trk == `MLT_TRK_3Q - 11'h1);
    wire locked = (lock_cnt != 27'h0);

    // ****************************************
    // trigger qualification
    // ****************************************
    wire trig_raw = en_act & win_act;
    wire trig_ok;
    reg trig_d;
    mlt_persist #(.CYC(FILT_CYC)) u_filt (
        .clk(CLOCK),
        .arst_n(ARST_N),
        .clr(srst),
        .din(trig_raw),
        .dout(trig_ok)
    );
    wire trig_new = trig_ok & !trig_d & !locked;

    // enable comparator hysteresis
    wire thr_high = !GATE_ON
        || (m_plain && state == ST_RED && !ANGLE_MAX);
    wire en_keep = thr_high ? en_2v : en_0v5;

    // ****************************************
    // sequence control
    // ****************************************
    always @* begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (first_cycle || trig_new) begin
                    next_state = ST_FULL;
                end else if (m_plain && en_act) begin
                    next_state = ST_ENO;
                end
            end
            ST_FULL: begin
                if (m_plain && !en_act && !pwr_run) begin
                    next_state = ST_IDLE;
                end else if (m_plain && trig_new) begin
                    next_state = ST_FULL;
                end else if (m_static && trk_end) begin
                    next_state = ST_IDLE;
                end else if (!m_static && trk_3q) begin
                    next_state = ST_RED;
                end
            end
            ST_RED: begin
                if (m_plain && !en_act && !pwr_run) begin
                    next_state = ST_IDLE;
                end else if (m_plain && trig_new) begin
                    next_state = ST_FULL;
                end else if (trk_end) begin
                    next_state = (m_plain && en_act) ? ST_ENO : ST_IDLE;
                end
            end
            ST_ENO: begin
                if (!m_plain || !en_act) begin
                    next_state = ST_IDLE;
                end else if (trig_new) begin
                    next_state = ST_FULL;
                end
            end
            default: next_state = ST_IDLE;
        endcase
    end

    wire restart = (next_state == ST_FULL)
        && (state != ST_FULL || (m_plain && trig_new));
    wire run = (state == ST_FULL) || (state == ST_RED);
    wire want_on = (state != ST_IDLE);
    wire gate_fell = gate_d & !GATE_ON;

    always @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            state <= ST_IDLE;
            trk <= 11'h0;
            lock_cnt <= 27'h0;
            osc_d <= 1'b0;
            sync_d <= 1'b0;
            trig_d <= 1'b0;
            en_act <= 1'b0;
            first_cycle <= 1'b1;
            pwr_run <= 1'b0;
            gate_d <= 1'b0;
        end else if (srst) begin
            state <= ST_IDLE;
            trk <= 11'h0;
            lock_cnt <= 27'h0;
            osc_d <= 1'b0;
            sync_d <= 1'b0;
            trig_d <= 1'b0;
            en_act <= 1'b0;
            first_cycle <= 1'b1;
            pwr_run <= 1'b0;
            gate_d <= 1'b0;
        end else begin
            state <= next_state;
            gate_d <= GATE_ON;
            osc_d <= osc;
            sync_d <= sync_lo;
            trig_d <= trig_ok;
            en_act <= en_act ? en_keep : en_on;
            if (restart) begin
                trk <= 11'h0;
            end else if (run && tick) begin
                trk <= trk + 11'h1;
            end
            if (state == ST_IDLE && first_cycle) begin
                first_cycle <= 1'b0;
                pwr_run <= 1'b1;
            end else if (next_state == ST_IDLE || trig_new) begin
                pwr_run <= 1'b0;
            end
            if (gate_fell) begin
                lock_cnt <= LOCK_CYC;
            end else if (locked) begin
                lock_cnt <= lock_cnt - 27'h1;
            end
        end
    end

    // ****************************************
    // protection latches
    // ****************************************
    always @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            sc_latch <= 1'b0;
            oc_latch <= 1'b0;
            ot_latch <= 1'b0;
            hw_oc <= 1'b0;
            integ <= 26'h0;
        end else if (srst) begin
            sc_latch <= 1'b0;
            oc_latch <= 1'b0;
            ot_latch <= 1'b0;
            hw_oc <= 1'b0;
            integ <= 26'h0;
        end else begin
            if (sh_500) begin
                sc_latch <= 1'b1;
            end
            if (ot_in) begin
                ot_latch <= 1'b1;
            end
            if (zc) begin
                hw_oc <= sh_100 & !sh_500;
            end else if (sh_100 && !sh_500) begin
                hw_oc <= 1'b1;
            end
            if (hw_oc) begin
                integ <= integ + 26'h2;
            end else if (integ != 26'h0) begin
                integ <= integ - 26'h1;
            end
            if (integ >= {OC_CYC[24:0], 1'b0}) begin
                oc_latch <= 1'b1;
            end
        end
    end

    // ****************************************
    // output stage, GATE_ON, ANGLE_MAX and STATIC_OUT changed at zero crossings, short clears GATE_ON at once
    // ****************************************
    always @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            GATE_ON <= 1'b0;
            ANGLE_MAX <= 1'b0;
            STATIC_OUT <= 1'b0;
            FAST_OFF <= 1'b0;
            EN_THR_HIGH <= 1'b1;
        end else if (srst) begin
            GATE_ON <= 1'b0;
            ANGLE_MAX <= 1'b0;
            STATIC_OUT <= 1'b0;
            FAST_OFF <= 1'b0;
            EN_THR_HIGH <= 1'b1;
        end else begin
            EN_THR_HIGH <= thr_high;
            FAST_OFF <= sc_latch | sh_500;
            if (sc_latch || sh_500) begin
                GATE_ON <= 1'b0;
            end else if (zc) begin
                GATE_ON <= want_on & !oc_latch & !ot_latch
                    & allow;
                ANGLE_MAX <= (state == ST_FULL) & !m_static;
                STATIC_OUT <= m_static;
            end
        end
    end

    // ****************************************
    // register port
    // ****************************************
    always @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            allow <= 1'b1;
            RD_DATA <= 8'h00;
        end else begin
            if (WR_EN && ADDR == `MLT_REG_CTRL) begin
                allow <= WR_DATA[`MLT_CTRL_ALLOW];
            end
            RD_DATA <= 8'h00;
            if (RD_EN) begin
                case (ADDR)
                    `MLT_REG_CTRL: RD_DATA <= {7'h0, allow};
                    `MLT_REG_STAT: RD_DATA <= {en_act, run, locked,
                        ot_latch, oc_latch, sc_latch, ANGLE_MAX, GATE_ON};
                    `MLT_REG_TRK: RD_DATA <= trk[10:3];
                    default: RD_DATA <= 8'h00;
                endcase
            end
        end
    end
endmodule // mlt_timer

// [hdl/mlt_regs.vh]
`ifndef MLT_REGS_VH
`define MLT_REGS_VH
// ****************************************
// clock and timing
// ****************************************
`define MLT_CLK_MHZ 200
`define MLT_T_FILT_MS 40
`define MLT_T_LOCK_MS 640
`define MLT_T_OC_MS 120
// ****************************************
// tracking divider, 2048 oscillator periods
// ****************************************
`define MLT_TRK_W 11
`define MLT_TRK_3Q 11'h600
`define MLT_TRK_LAST 11'h7ff
// ****************************************
// mode selector codes
// ****************************************
`define MLT_MODE_PLAIN 2'h0
`define MLT_MODE_STATIC 2'h1
`define MLT_MODE_SWOFF 2'h2
// ****************************************
// register map
// ****************************************
`define MLT_REG_CTRL 2'h0
`define MLT_REG_STAT 2'h1
`define MLT_REG_TRK 2'h2
`define MLT_CTRL_RST 8'h01
`define MLT_CTRL_ALLOW 0
`endif

// [hdl/mlt_sync.v]
`timescale 1ns/10ps
// ****************************************
// two stage synchroniser for comparator levels
// ****************************************
module mlt_sync #(
    parameter W = 13
) (
    input wire clk,
    input wire arst_n,
    input wire [W-1:0] din,
    output reg [W-1:0] dout
);
    reg [W-1:0] meta;

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            meta <= {W{1'b0}};
            dout <= {W{1'b0}};
        end else begin
            meta <= din;
            dout <= meta;
        end
    end
endmodule // mlt_sync

// [hdl/mlt_persist.v]
`timescale 1ns/10ps
// ****************************************
// persistence filter, level must hold cyc cycles
// ****************************************
module mlt_persist #(
    parameter [22:0] CYC = 23'h7a_1200
) (
    input wire clk,
    input wire arst_n,
    input wire clr,
    input wire din,
    output reg dout
);
    reg [22:0] cnt;

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt <= 23'h0;
            dout <= 1'b0;
        end else if (clr || !din) begin
            cnt <= 23'h0;
            dout <= 1'b0;
        end else if (cnt >= CYC - 23'h1) begin
            dout <= 1'b1;
        end else begin
            cnt <= cnt + 23'h1;
        end
    end
endmodule // mlt_persist

// [tb/mlt_timer_properties.sv]
`timescale 1ns/10ps
`include "mlt_regs.vh"
// ****************************************
// port checks of the load timer
// ****************************************
module mlt_timer_props (
    // clock and reset
    input wire CLOCK,
    input wire ARST_N,
    // inputs
    input wire SUPPLY_OK,
    input wire OVER_TEMP,
    input wire [1:0] MODE_SEL,
    input wire SYNC_BELOW,
    input wire SHUNT_ABOVE_500MV,
    // outputs
    input wire GATE_ON,
    input wire ANGLE_MAX,
    input wire STATIC_OUT,
    input wire FAST_OFF,
    input wire EN_THR_HIGH
);
    reg sync_d;
    reg [3:0] zc_age;
    reg [2:0] ot_age;
    always @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            sync_d <= 1'b0;
            zc_age <= 4'hf;
            ot_age <= 3'h0;
        end else begin
            sync_d <= SYNC_BELOW;
            if (SYNC_BELOW && !sync_d)
                zc_age <= 4'h0;
            else if (zc_age != 4'hf)
                zc_age <= zc_age + 4'h1;
            if (!SUPPLY_OK)
                ot_age <= 3'h0;
            else if (ot_age == 3'h0 ? OVER_TEMP : ot_age != 3'h7)
                ot_age <= ot_age + 3'h1;
        end
    end
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!ARST_N);
    short_trip_a: assert property (
        $rose(SHUNT_ABOVE_500MV) && SUPPLY_OK |-> ##3 FAST_OFF && !GATE_ON)
        else $error("fast off late");
    fast_hold_a: assert property (
        FAST_OFF && SUPPLY_OK |=> FAST_OFF) else $error("fast off lost");
    supply_reset_a: assert property (
        !SUPPLY_OK [*4] |-> !GATE_ON && !FAST_OFF && !ANGLE_MAX
        && !STATIC_OUT && EN_THR_HIGH) else $error("supply reset missed");
    gate_zc_a: assert property (
        $rose(GATE_ON) |-> zc_age < 4'h8) else $error("gate off sync");
    angle_zc_a: assert property (
        $fell(ANGLE_MAX) && GATE_ON |-> zc_age < 4'h8)
        else $error("angle off sync");
    static_zc_a: assert property (
        $rose(STATIC_OUT) |-> zc_age < 4'h8 && MODE_SEL == `MLT_MODE_STATIC)
        else $error("static output wrong");
    thr_idle_a: assert property (
        (!GATE_ON && !ANGLE_MAX) [*3] |-> EN_THR_HIGH)
        else $error("idle threshold low");
    thr_max_a: assert property (
        (GATE_ON && ANGLE_MAX) [*3] |-> !EN_THR_HIGH)
        else $error("max threshold high");
    temp_off_a: assert property (
        $rose(GATE_ON) |-> ot_age < 3'h5) else $error("on after overtemp");
    cover property ($rose(GATE_ON));
    cover property ($fell(ANGLE_MAX) && GATE_ON);
    cover property ($rose(FAST_OFF));
    cover property ($rose(STATIC_OUT));
endmodule // mlt_timer_props
bind mlt_timer mlt_timer_props mlt_timer_props_i (
    .CLOCK(CLOCK), .ARST_N(ARST_N), .SUPPLY_OK(SUPPLY_OK),
    .OVER_TEMP(OVER_TEMP), .MODE_SEL(MODE_SEL), .SYNC_BELOW(SYNC_BELOW),
    .SHUNT_ABOVE_500MV(SHUNT_ABOVE_500MV), .GATE_ON(GATE_ON),
    .ANGLE_MAX(ANGLE_MAX), .STATIC_OUT(STATIC_OUT), .FAST_OFF(FAST_OFF),
    .EN_THR_HIGH(EN_THR_HIGH));

// [tb/mlt_mains_model.sv]
`timescale 1ns/10ps
// ****************************************
// mains sync, oscillator and load current
// ****************************************
module mlt_mains_model #(
    parameter HALF = 200,
    parameter OSC = 4
) (
    input wire clk,
    input wire gate_on,
    input wire oc_load,
    output reg sync_below,
    output reg osc_level,
    output wire shunt_100
);
    integer n = 0;
    initial begin
        sync_below = 1'b0;
        osc_level = 1'b0;
    end
    always @(posedge clk) begin
        n <= (n + 1) % HALF;
        sync_below <= n < 20;
        osc_level <= (n % OSC) < (OSC / 2);
    end
    assign shunt_100 = gate_on && oc_load;
endmodule // mlt_mains_model

// [tb/testbench.sv]
`timescale 1ns/10ps
`include "mlt_regs.vh"
`define CMP(got, exp) begin \
    checks++; \
    if ((got) !== (exp)) begin \
        mismatches++; \
        $display("BAD %0t got %h want %h", $time, got, exp); \
    end \
end
module testbench;
    reg clock = 1'b0;
    reg arst_n = 1'b0;
    reg supply_ok = 1'b1;
    reg over_temp = 1'b0;
    reg [1:0] mode_sel = `MLT_MODE_SWOFF;
    reg en = 1'b0;
    reg [1:0] win = 2'b00;
    reg short_in = 1'b0;
    reg oc_load = 1'b0;
    reg [1:0] addr = 2'h0;
    reg [7:0] wr_data = 8'h00;
    reg wr_en = 1'b0;
    reg rd_en = 1'b0;
    reg rd_seen = 1'b0;
    reg [15:0] notes[$];
    reg [15:0] note;
    integer mismatches = 0;
    integer checks = 0;
    integer cycles = 0;
    integer mark = 0;
    wire [7:0] rd_data;
    wire gate_on;
    wire osc_level;
    wire sync_below;
    wire shunt_100;
    always #2.5 clock = ~clock;
    mlt_timer #(.FILT_CYC(23'h14), .LOCK_CYC(27'h32), .OC_CYC(26'h1e))
        mlt_timer_i (
        .CLOCK(clock), .ARST_N(arst_n), .SUPPLY_OK(supply_ok),
        .OVER_TEMP(over_temp), .MODE_SEL(mode_sel), .EN_ABOVE_TURNON(en),
        .EN_ABOVE_2V(en), .EN_ABOVE_0V5(en), .WIN_ABOVE_UPPER(win[1]),
        .WIN_BELOW_LOWER(win[0]), .OSC_LEVEL(osc_level),
        .SYNC_BELOW(sync_below), .SHUNT_ABOVE_500MV(short_in),
        .SHUNT_ABOVE_100MV(shunt_100), .ADDR(addr), .WR_DATA(wr_data),
        .WR_EN(wr_en), .RD_EN(rd_en), .RD_DATA(rd_data), .GATE_ON(gate_on),
        .ANGLE_MAX(), .STATIC_OUT(), .FAST_OFF(), .EN_THR_HIGH());
    mlt_mains_model mlt_mains_model_i (.clk(clock), .gate_on(gate_on),
        .oc_load(oc_load), .sync_below(sync_below), .osc_level(osc_level),
        .shunt_100(shunt_100));
    task wt(input integer n);
        repeat (n) @(posedge clock);
    endtask
    task upto(input integer n);
        while (cycles < mark + n) @(posedge clock);
    endtask
    task rd(input [1:0] a, input [7:0] m, input [7:0] e);
        @(posedge clock);
        rd_en <= 1'b1;
        addr <= a;
        notes.push_back({m, e});
        @(posedge clock);
        rd_en <= 1'b0;
    endtask
    task st(input [7:0] m, input [7:0] e);
        rd(`MLT_REG_STAT, m, e);
    endtask
    task wr(input [1:0] a, input [7:0] d);
        @(posedge clock);
        wr_en <= 1'b1;
        addr <= a;
        wr_data <= d;
        @(posedge clock);
        wr_en <= 1'b0;
    endtask
    task trig(input integer n);
        @(posedge clock);
        win <= ($urandom_range(1) != 0) ? 2'b10 : 2'b01;
        wt(n);
        win <= 2'b00;
    endtask
    task wait_gate(input v);
        integer k;
        for (k = 0; k < 9000 && gate_on !== v; k++)
            @(posedge clock);
    endtask
    task cycle_supply;
        @(posedge clock);
        supply_ok <= 1'b0;
        wt(10);
        st(8'h7f, 8'h00);
        supply_ok <= 1'b1;
    endtask
    task print_verdict;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    always @(posedge clock) begin
        rd_seen <= rd_en;
        cycles <= cycles + 1;
        if (rd_seen) begin
            note = notes.pop_front();
            `CMP(rd_data & note[15:8], note[7:0])
        end
        if (cycles == 45000) begin
            mismatches++;
            print_verdict;
        end
    end
    initial begin
        void'($urandom(32'h332e_5fd7));
        wt(5);
        arst_n <= 1'b1;
        mark = cycles;
        rd(`MLT_REG_CTRL, 8'h01, `MLT_CTRL_RST);
        wr(2'h3, 8'($urandom));
        rd(2'h3, 8'hff, 8'h00);
        wr(`MLT_REG_CTRL, 8'($urandom) | 8'h01);
        rd(`MLT_REG_CTRL, 8'h01, 8'h01);
        upto(300);
        st(8'h03, 8'h03);
        upto(1470 * 4);
        st(8'h03, 8'h03);
        upto(1700 * 4);
        st(8'h03, 8'h01);
        upto(2200 * 4);
        st(8'h43, 8'h00);
        mode_sel <= `MLT_MODE_STATIC;
        en <= 1'b1;
        trig(10);
        wt(60);
        st(8'h40, 8'h00);
        mark = cycles;
        trig(40);
        st(8'h40, 8'h40);
        upto(300);
        st(8'h01, 8'h01);
        upto(1950 * 4);
        st(8'h01, 8'h01);
        wait_gate(1'b0);
        trig(30);
        st(8'h60, 8'h20);
        mode_sel <= `MLT_MODE_PLAIN;
        wt(300);
        st(8'h43, 8'h01);
        mark = cycles;
        trig(40);
        upto(300);
        st(8'h03, 8'h03);
        upto(1000 * 4);
        mark = cycles;
        trig(40);
        upto(1470 * 4);
        st(8'h03, 8'h03);
        upto(1700 * 4);
        st(8'h03, 8'h01);
        upto(2300 * 4);
        st(8'h43, 8'h01);
        en <= 1'b0;
        wt(210);
        st(8'h01, 8'h00);
        wt(60);
        en <= 1'b1;
        oc_load <= 1'b1;
        wait_gate(1'b1);
        wt(100);
        st(8'h09, 8'h09);
        wt(200);
        st(8'h09, 8'h08);
        oc_load <= 1'b0;
        cycle_supply;
        wt(300);
        st(8'h01, 8'h01);
        over_temp <= 1'b1;
        wt(5);
        over_temp <= 1'b0;
        wt(400);
        st(8'h11, 8'h10);
        short_in <= 1'b1;
        wt(5);
        short_in <= 1'b0;
        st(8'h04, 8'h04);
        cycle_supply;
        wt(300);
        st(8'h1d, 8'h01);
        print_verdict;
    end
endmodule // testbench
